// File: hdl/gd_host_ctrl.sv
// Host controller that drives one isolated gate driver's control and reset pins and watches its fault pin.
// How it works
// - Inverting global mode: fault tied to noninverting input
// - Shared fault bus disables all drivers
// - Poll each fault, reset each driver alone
// - Auto-reset: gate command doubles as reset
// - Gate-low first, then reset low (auto-reset takes both low in the same cycle)
// - Drive both control inputs push-pull, except noninverting in inverting global mode
`timescale 1ns/10ps
module gd_host_ctrl
  import gd_host_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic pwm_cmd_i,
  input wire logic invert_mode_i,
  input wire wiring_mode_t wiring_mode_i,
  input wire logic fault_pin_i,
  input wire logic recover_req_i,
  output logic noninverting_gate_in_o,
  output logic inverting_gate_in_o,
  output logic noninverting_gate_oe_o,
  output logic reset_n_o,
  output logic fault_seen_o,
  output logic fault_short_o,
  output logic busy_o
);
  host_state_t state_reg;
  host_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] low_cnt_reg;
  logic [CNT_W-1:0] low_cnt_next;
  logic gate_cmd_reg;
  logic gate_cmd_next;
  logic reset_n_reg;
  logic reset_n_next;
  logic fault_seen_reg;
  logic short_reg;
  logic short_next;
  logic fault_low;
  logic gate_allowed;
  logic cnt_done;
  logic auto_mode;
  logic global_mode;
  logic in_run;
  // Fault pulse measurement for the auto-reset wiring.
  logic low_cnt_full;
  logic [CNT_W-1:0] low_cnt_inc;
  logic pulse_short;
  logic fault_seen_next;
  logic short_clear;

  pin_sync_if fault_if ();

  assign fault_if.raw = fault_pin_i;

  pin_sync u_fault_sync (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .port_io(fault_if)
  );

  // The fault pin is open drain at the device; low means a latched fault.
  assign fault_low = ~fault_if.level;
  assign auto_mode = (wiring_mode_i == MODE_AUTO);
  assign global_mode = (wiring_mode_i == MODE_GLOBAL);
  assign cnt_done = (cnt_reg == CNT_ZERO);
  // Gate command is held low outside ST_RUN so the device sees gate-low before reset.
  assign in_run = (state_reg == ST_RUN);
  assign gate_allowed = in_run && !fault_low;
  assign gate_cmd_next = gate_allowed & pwm_cmd_i;

  // Auto wiring: reset follows the gate command, so the off phase clears the latch.
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    reset_n_next = 1'b1;
    unique case (state_reg)
      ST_RUN:
      begin
        if (auto_mode)
        begin
          reset_n_next = gate_cmd_next;
        end
        if (fault_low && !auto_mode)
        begin
          state_next = ST_FAULT_WAIT;
          cnt_next = SHUTDOWN_CYC;
        end
      end
      ST_FAULT_WAIT:
      begin
        // Let the soft shutdown finish before anything else happens.
        if (cnt_done)
        begin
          if (recover_req_i)
          begin
            state_next = ST_GATE_LOW;
            cnt_next = SETUP_CYC;
          end
        end
        else
        begin
          cnt_next = cnt_reg - CNT_ONE;
        end
      end
      ST_GATE_LOW:
      begin
        if (cnt_done)
        begin
          state_next = ST_RESET;
          cnt_next = RESET_CYC;
        end
        else
        begin
          cnt_next = cnt_reg - CNT_ONE;
        end
      end
      ST_RESET:
      begin
        reset_n_next = 1'b0;
        if (cnt_done)
        begin
          state_next = ST_RELEASE;
        end
        else
        begin
          cnt_next = cnt_reg - CNT_ONE;
        end
      end
      ST_RELEASE:
      begin
        // Wait for the fault line to come back high; a shared bus may still be held by another driver.
        if (!fault_low)
        begin
          state_next = ST_RUN;
        end
      end
    endcase
  end

  // Measure each fault pulse so a pulse shorter than the least width is flagged in auto-reset wiring.
  // The count saturates at the least width, so a long fault can never wrap back to a short one.
  assign low_cnt_full = (low_cnt_reg == FAULT_MIN_CYC);
  assign low_cnt_inc = low_cnt_full ? low_cnt_reg : low_cnt_reg + CNT_ONE;
  assign low_cnt_next = fault_low ? low_cnt_inc : CNT_ZERO;
  // At the rising edge the current cycle is still low, so the next count is the whole pulse length.
  assign pulse_short = fault_if.rise && auto_mode && (low_cnt_next < FAULT_MIN_CYC);
  assign short_next = short_reg | pulse_short;
  // A new short pulse wins over the recovery clear in the same cycle.
  assign short_clear = recover_req_i & ~pulse_short;
  // A new fault edge wins over the recovery clear in the same cycle.
  assign fault_seen_next = fault_if.fall | (fault_seen_reg & ~recover_req_i);

  // Sequencer state and its shared cycle counter.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg <= ST_RUN;
      cnt_reg <= CNT_ZERO;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // Pin drivers are registered so the device never sees a combinational glitch.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      gate_cmd_reg <= 1'b0;
      reset_n_reg <= 1'b1;
    end
    else
    begin
      gate_cmd_reg <= gate_cmd_next;
      reset_n_reg <= reset_n_next;
    end
  end

  // Sticky status flags and the pulse width counter.
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      low_cnt_reg <= CNT_ZERO;
      fault_seen_reg <= 1'b0;
      short_reg <= 1'b0;
    end
    else
    begin
      low_cnt_reg <= low_cnt_next;
      fault_seen_reg <= fault_seen_next;
      short_reg <= short_next & ~short_clear;
    end
  end

  // Inverting wiring: active input is the inverting one, noninverting held high, or left to the fault bus in global wiring.
  assign inverting_gate_in_o = invert_mode_i ? ~gate_cmd_reg : 1'b0;
  assign noninverting_gate_in_o = invert_mode_i ? 1'b1 : gate_cmd_reg;
  // In inverting global wiring the noninverting pin is the fault bus, so release it.
  assign noninverting_gate_oe_o = ~(invert_mode_i & global_mode);
  assign reset_n_o = reset_n_reg;
  assign fault_seen_o = fault_seen_reg;
  assign fault_short_o = short_reg;
  assign busy_o = ~in_run;
endmodule : gd_host_ctrl

// File: hdl/pin_sync.sv
// Three-stage synchroniser with agreement filter for one asynchronous pin.
`timescale 1ns/10ps
module pin_sync
  import gd_host_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  pin_sync_if.sync port_io
);
  logic [2:0] stage_reg;
  logic level_reg;
  logic level_next;
  logic agree;

  // The first stage feeds only the second; the filter looks at stages two and three.
  assign agree = (stage_reg[1] == stage_reg[2]);
  assign level_next = agree ? stage_reg[2] : level_reg;
  assign port_io.level = level_reg;
  assign port_io.fall = level_reg & ~level_next;
  assign port_io.rise = ~level_reg & level_next;

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      stage_reg <= 3'h7;
      level_reg <= 1'b1;
    end
    else
    begin
      stage_reg <= {stage_reg[1:0], port_io.raw};
      level_reg <= level_next;
    end
  end
endmodule : pin_sync

// File: shared/gd_host_pkg.sv
// Package with constants and types for the gate driver host controller.
package gd_host_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Time that the device needs to finish its soft shutdown after a fault.
  localparam int unsigned SHUTDOWN_NS = 3000;
  // Least width of the fault pulse in auto-reset wiring.
  localparam int unsigned FAULT_MIN_NS = 3000;
  // Least time the gate-low command stands before reset is taken low.
  localparam int unsigned GATE_LOW_SETUP_NS = 1000;
  // Least width of the reset pulse driven to the device.
  localparam int unsigned RESET_PULSE_NS = 1000;
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] SHUTDOWN_CYC = CNT_W'((SHUTDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] FAULT_MIN_CYC = CNT_W'((FAULT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'((GATE_LOW_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] RESET_CYC = CNT_W'((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  // Wiring mode of the driver as seen by the controller.
  typedef enum logic [1:0] {
    MODE_LOCAL = 2'h0,
    MODE_AUTO = 2'h1,
    MODE_GLOBAL = 2'h2
  } wiring_mode_t;
  typedef enum {
    ST_RUN,
    ST_FAULT_WAIT,
    ST_GATE_LOW,
    ST_RESET,
    ST_RELEASE
  } host_state_t;
endpackage : gd_host_pkg

// File: shared/pin_sync_if.sv
// Interface carrying one raw pin into the synchroniser and its filtered level out.
`timescale 1ns/10ps
interface pin_sync_if;
  logic raw;
  logic level;
  logic fall;
  logic rise;
  modport sync (input raw, output level, output fall, output rise);
  modport user (output raw, input level, input fall, input rise);
endinterface : pin_sync_if

// File: test/gd_device_model.sv
// Behavioural model of the isolated gate driver.
`timescale 1ns/10ps
module gd_device_model (
  input wire logic noninverting_gate_in_i,
  input wire logic inverting_gate_in_i,
  input wire logic reset_n_i,
  input wire logic desaturation_sense_i,
  input wire logic supply_undervolt_lock_i,
  output logic fault_pull_o,
  output logic gate_drive_out_o
);
  logic latch_reg = 1'b0;
  logic hold_reg = 1'b0;
  logic input_block = 1'b0;
  always @(posedge desaturation_sense_i)
    latch_reg = reset_n_i;
  always @(negedge reset_n_i)
  begin
    latch_reg = 1'b0;
    input_block = 1'b0;
  end
  // Stretching keeps a fault seen by a poller even when auto-reset clears it early.
  always @(posedge latch_reg)
  begin
    hold_reg = 1'b1;
    #3000 hold_reg = 1'b0;
    input_block = latch_reg;
  end
  assign fault_pull_o = latch_reg | hold_reg;
  // A supply lockout only forces the gate low; it never touches the fault latch or the fault pin.
  assign gate_drive_out_o = noninverting_gate_in_i & ~inverting_gate_in_i & ~latch_reg & ~input_block
    & ~supply_undervolt_lock_i;
endmodule : gd_device_model

// File: test/gd_host_ctrl_bench.sv
// Bench for the gate driver host controller against a device model.
`timescale 1ns/10ps
module gd_host_ctrl_bench
  import gd_host_pkg::*;
();
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic pwm_cmd_i = 1'b0;
  logic invert_mode_i = 1'b0;
  wiring_mode_t wiring_mode_i = MODE_LOCAL;
  logic recover_req_i = 1'b0;
  logic desaturation_sense = 1'b0;
  logic undervolt = 1'b0;
  logic noninverting_gate_in_o, inverting_gate_in_o, noninverting_gate_oe_o, reset_n_o, fault_seen_o, busy_o;
  logic fault_short_o;
  logic fault_pull, gate;
  int n_mismatch = 0;
  int checks_done = 0;
  // The pulled-up fault line is also the noninverting pin when the host lets go of it.
  wire fault_pin = ~fault_pull;
  wire noninv_pin = noninverting_gate_oe_o ? noninverting_gate_in_o : fault_pin;
  gd_host_ctrl u_gd_host_ctrl (.*, .fault_pin_i(fault_pin));
  gd_device_model u_gd_device_model (.noninverting_gate_in_i(noninv_pin), .inverting_gate_in_i(inverting_gate_in_o),
    .reset_n_i(reset_n_o), .desaturation_sense_i(desaturation_sense), .supply_undervolt_lock_i(undervolt),
    .fault_pull_o(fault_pull), .gate_drive_out_o(gate));
  initial forever #50 mclk_i = ~mclk_i;
  task automatic check(logic seen, logic exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(int n);
    repeat (n) @(negedge mclk_i);
  endtask : cyc
  task automatic start(logic inv, wiring_mode_t m);
    @(posedge mclk_i);
    arst_n_i <= 1'b0;
    invert_mode_i <= inv;
    wiring_mode_i <= m;
    pwm_cmd_i <= 1'b1;
    cyc(2);
    @(posedge mclk_i);
    arst_n_i <= 1'b1;
    cyc(4);
  endtask : start
  task automatic trip;
    desaturation_sense = 1'b1;
    #50 desaturation_sense = 1'b0;
    cyc(8);
  endtask : trip
  task automatic recover;
    int i;
    cyc(40);
    check(gate, 1'b0);
    @(posedge mclk_i);
    recover_req_i <= 1'b1;
    @(posedge mclk_i);
    recover_req_i <= 1'b0;
    for (i = 0; i < 300 && busy_o !== 1'b0; i++) @(negedge mclk_i);
    cyc(3);
    check(fault_seen_o, 1'b0);
    check(fault_pin, 1'b1);
    check(gate, 1'b1);
  endtask : recover
  task automatic t_local;
    start(1'b0, MODE_LOCAL);
    trip();
    check(fault_seen_o, 1'b1);
    check(busy_o, 1'b1);
    recover();
    $display("local test done");
  endtask : t_local
  task automatic t_global;
    start(1'b1, MODE_GLOBAL);
    check(noninverting_gate_oe_o, 1'b0);
    check(noninverting_gate_in_o, 1'b1);
    check(gate, 1'b1);
    trip();
    check(inverting_gate_in_o, 1'b1);
    recover();
    $display("global test done");
  endtask : t_global
  task automatic t_auto;
    start(1'b0, MODE_AUTO);
    trip();
    check(gate, 1'b0);
    @(posedge mclk_i);
    pwm_cmd_i <= 1'b0;
    cyc(3);
    check(reset_n_o, 1'b0);
    check(fault_pin, 1'b0);
    cyc(30);
    check(fault_pin, 1'b1);
    check(fault_short_o, 1'b0);
    @(posedge mclk_i);
    pwm_cmd_i <= 1'b1;
    cyc(3);
    check(gate, 1'b1);
    $display("auto test done");
  endtask : t_auto
  task automatic t_undervolt;
    start(1'b0, MODE_LOCAL);
    undervolt = 1'b1;
    cyc(8);
    check(gate, 1'b0);
    check(fault_pin, 1'b1);
    check(fault_seen_o, 1'b0);
    check(busy_o, 1'b0);
    undervolt = 1'b0;
    cyc(2);
    check(gate, 1'b1);
    $display("undervolt test done");
  endtask : t_undervolt
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial
  begin
    t_local();
    t_global();
    t_auto();
    t_undervolt();
    print_verdict();
  end
  // The tests need some 250 cycles; 6000 cycles, some 24 times that, means a hang.
  initial
  begin
    #600000;
    n_mismatch++;
    print_verdict();
  end
endmodule : gd_host_ctrl_bench

// File: test/gd_host_ctrl_properties.sv
// Port checks for the gate driver host controller.
`timescale 1ns/10ps
module gd_host_ctrl_properties
  import gd_host_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic invert_mode_i,
  input wire wiring_mode_t wiring_mode_i,
  input wire logic fault_pin_i,
  input wire logic noninverting_gate_in_o,
  input wire logic inverting_gate_in_o,
  input wire logic noninverting_gate_oe_o,
  input wire logic reset_n_o,
  input wire logic busy_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  wire gate_on = noninverting_gate_in_o & ~inverting_gate_in_o;
  wire fsm_mode = wiring_mode_i != MODE_AUTO;
  // The release edge is left out: the registers still hold their reset values one cycle later.
  wire auto_noninv = arst_n_i && !fsm_mode && !invert_mode_i;
  sequence reset_falls;
    $fell(reset_n_o) && fsm_mode;
  endsequence
  a_gate_low_first: assert property (reset_falls |-> !gate_on && !$past(gate_on))
    else $error("reset taken with gate on");
  a_reset_width: assert property (reset_falls |-> ##10 !reset_n_o ##1 reset_n_o)
    else $error("reset pulse width wrong");
  a_fault_stops_gate: assert property ((fsm_mode && !fault_pin_i) [*7] |-> !gate_on)
    else $error("gate on during fault");
  a_busy_holds_low: assert property (busy_o && $past(busy_o) |-> !gate_on)
    else $error("gate on during recovery");
  a_auto_reset_tracks: assert property (auto_noninv |=> reset_n_o == noninverting_gate_in_o)
    else $error("reset not tied to gate command");
  a_pin_ownership: assert property (1'b1 |=> noninverting_gate_oe_o != (invert_mode_i && wiring_mode_i == MODE_GLOBAL))
    else $error("noninverting pin ownership wrong");
endmodule : gd_host_ctrl_properties
bind gd_host_ctrl gd_host_ctrl_properties u_props (.*);
